// >>> rtl/aslr_pkg.sv
package aslr_pkg;

   // -----------------------------------------------------------------
   // Widths and field positions
   // -----------------------------------------------------------------
   localparam int WORD_W = 24;
   localparam int EXT_W = 8;
   localparam int LONG_W = 48;
   localparam int ACC_W = 56;
   localparam int IMM_W = 8;
   localparam int UPPER_LSB = 24;
   localparam int UPPER_MSB = 47;
   localparam int NUM_ACC = 2;

   // -----------------------------------------------------------------
   // Saturation constants
   // -----------------------------------------------------------------
   localparam logic [23:0] SAT_POS_WORD = 24'h7fffff;
   localparam logic [23:0] SAT_NEG_WORD = 24'h800000;
   localparam logic [23:0] SAT_POS_LOW = 24'hffffff;
   localparam logic [23:0] SAT_NEG_LOW = 24'h000000;
   localparam logic [23:0] ZERO_WORD = 24'h000000;

   // -----------------------------------------------------------------
   // Rounding constants, one set per scaling mode; the reserved code uses the no-scale set
   // -----------------------------------------------------------------
   localparam logic [55:0] LOWER_MASK = 56'h00_000000_ffffff;
   localparam logic [55:0] HALF_NONE = 56'h00_000000_800000;
   localparam logic [55:0] MASK_NONE = 56'h00_000000_ffffff;
   localparam logic [55:0] HALF_DOWN = 56'h00_000001_000000;
   localparam logic [55:0] MASK_DOWN = 56'h00_000001_ffffff;
   localparam logic [55:0] HALF_UP = 56'h00_000000_400000;
   localparam logic [55:0] MASK_UP = 56'h00_000000_7fffff;

   // -----------------------------------------------------------------
   // Enumerations
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      SCALE_NONE = 2'b00,
      SCALE_DOWN = 2'b01,
      SCALE_UP = 2'b10,
      SCALE_RSVD = 2'b11
   } aslr_scale_t;

   typedef enum logic [1:0] {
      PART_FULL = 2'b00,
      PART_EXT = 2'b01,
      PART_UPPER = 2'b10,
      PART_LOWER = 2'b11
   } aslr_part_t;

   typedef enum logic [2:0] {
      OP_WORD = 3'b000,
      OP_LONG = 3'b001,
      OP_EXT = 3'b010,
      OP_UPPER = 3'b011,
      OP_LOWER = 3'b100,
      OP_IMM = 3'b101,
      OP_MPY = 3'b110,
      OP_RND = 3'b111
   } aslr_op_t;

   // -----------------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic acc_sel;
      aslr_op_t op;
      logic [47:0] data;
   } aslr_wr_t;

   typedef struct packed {
      logic valid;
      logic acc_sel;
      aslr_part_t part;
   } aslr_rd_t;

   typedef struct packed {
      logic valid;
      logic acc_sel;
   } aslr_long_rd_t;

   typedef struct packed {
      logic valid;
      logic limited;
      logic [23:0] data;
   } aslr_bus_t;

endpackage

// >>> rtl/aslr_shift_limit.sv
`timescale 1ns/1ps

// Scaling shifter followed by limiter for one data bus path.
module aslr_shift_limit
   import aslr_pkg::*;
(
   input wire logic [55:0] acc,
   input wire aslr_pkg::aslr_scale_t scale,
   output logic [23:0] upper,
   output logic [23:0] lower,
   output logic ovf
);
   import aslr_pkg::*;

   // ----------------------------------------------------------------
   // Shifter
   // ----------------------------------------------------------------
   wire logic [55:0] shl = {acc[54:0], 1'h0};
   wire logic [55:0] shr = {acc[55], acc[55:1]};
   // Reserved scale code passes the value unshifted.
   wire logic [55:0] shifted = (scale == SCALE_UP) ? shl :
                               (scale == SCALE_DOWN) ? shr : acc;

   // ----------------------------------------------------------------
   // Limiter
   // ----------------------------------------------------------------
   // The test runs on the shifted value, so a left scale can itself
   // push a value out of range.
   wire logic [8:0] top = shifted[55:47];
   assign ovf = !((top == '0) || (top == '1));
   // Sign comes from the extension MSB before scaling; a left scale can alter that bit.
   wire logic neg = acc[55];
   assign upper = !ovf ? shifted[UPPER_MSB:UPPER_LSB] :
                  neg ? SAT_NEG_WORD : SAT_POS_WORD;
   assign lower = !ovf ? shifted[WORD_W-1:0] :
                  neg ? SAT_NEG_LOW : SAT_POS_LOW;

endmodule

// >>> rtl/aslr_datapath.sv
`timescale 1ns/1ps

module aslr_datapath
   import aslr_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire aslr_pkg::aslr_scale_t scale,
   input wire aslr_pkg::aslr_wr_t wr,
   input wire aslr_pkg::aslr_rd_t first_rd,
   input wire aslr_pkg::aslr_rd_t second_rd,
   input wire aslr_pkg::aslr_long_rd_t long_rd,
   output aslr_pkg::aslr_bus_t first_operand_bus,
   output aslr_pkg::aslr_bus_t second_operand_bus,
   output logic [55:0] acc_a,
   output logic [55:0] acc_b
);
   import aslr_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Gives extension and upper word for a word written to an accumulator.
   function automatic logic [31:0] sext_word(input logic [23:0] w);
      return {{EXT_W{w[WORD_W-1]}}, w};
   endfunction

   function automatic logic [55:0] sext_long(input logic [47:0] l);
      return {{EXT_W{l[LONG_W-1]}}, l};
   endfunction

   // Picks the raw part of an accumulator for an unlimited read.
   function automatic logic [23:0] raw_part(input logic [55:0] a,
                                            input aslr_part_t p);
      logic [23:0] r;
      r = ZERO_WORD;
      case (p)
         // The extension reads back sign-extended, so it keeps its value
         // as a signed count of whole units on the wider bus.
         PART_EXT: r = {{(WORD_W-EXT_W){a[ACC_W-1]}},
                        a[ACC_W-1:LONG_W]};
         PART_UPPER: r = a[UPPER_MSB:UPPER_LSB];
         PART_LOWER: r = a[WORD_W-1:0];
         default: r = ZERO_WORD;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Accumulator storage
   // ----------------------------------------------------------------
   // The 8 extension bits let a value grow to about +/-256 before
   // a true overflow.
   logic [55:0] acc_q [NUM_ACC];
   logic [55:0] acc_d;
   aslr_bus_t first_q, second_q, first_d, second_d;

   wire logic [55:0] wr_src = acc_q[wr.acc_sel];

   // ----------------------------------------------------------------
   // Convergent rounding
   // ----------------------------------------------------------------
   logic [55:0] rnd_half, rnd_mask;
   always_comb begin
      case (scale)
         SCALE_DOWN: begin
            rnd_half = HALF_DOWN;
            rnd_mask = MASK_DOWN;
         end
         SCALE_UP: begin
            rnd_half = HALF_UP;
            rnd_mask = MASK_UP;
         end
         default: begin
            rnd_half = HALF_NONE;
            rnd_mask = MASK_NONE;
         end
      endcase
   end

   wire logic [55:0] rnd_sum = wr_src + rnd_half;
   wire logic rnd_tie = (wr_src & rnd_mask) == rnd_half;
   // On a tie the added half always carries into the kept LSB; clearing
   // that bit afterwards leaves the even neighbour in both cases.
   wire logic [55:0] rnd_even = rnd_tie ? (rnd_sum & ~(rnd_half << 1))
                                        : rnd_sum;
   wire logic [55:0] rnd_res = rnd_even & ~rnd_mask & ~LOWER_MASK;
   // In scale-up mode the kept LSB sits in the lower word, which every
   // rounding clears too; the result then drops one bit of precision.

   // ----------------------------------------------------------------
   // Fractional multiply
   // ----------------------------------------------------------------
   // Minus one times minus one does not fit and wraps; nothing limits it.
   wire logic signed [47:0] mpy_int = $signed(wr.data[47:24]) *
                                      $signed(wr.data[23:0]);
   // Drop the duplicate sign bit and append a zero LSB.
   wire logic [47:0] mpy_frac = {mpy_int[46:0], 1'b0};

   // ----------------------------------------------------------------
   // Accumulator write path
   // ----------------------------------------------------------------
   wire logic [23:0] imm_word = {wr.data[IMM_W-1:0],
                                 {(WORD_W-IMM_W){1'b0}}};
   // Ops on the extension, upper or lower word alone never sign-extend.
   always_comb begin
      acc_d = wr_src;
      case (wr.op)
         OP_WORD: acc_d = {sext_word(wr.data[23:0]), ZERO_WORD};
         OP_LONG: acc_d = sext_long(wr.data);
         OP_EXT: acc_d = {wr.data[EXT_W-1:0], wr_src[47:0]};
         OP_UPPER: acc_d = {wr_src[55:48], wr.data[23:0], wr_src[23:0]};
         OP_LOWER: acc_d = {wr_src[55:24], wr.data[23:0]};
         OP_IMM: acc_d = {sext_word(imm_word), ZERO_WORD};
         OP_MPY: acc_d = sext_long(mpy_frac);
         OP_RND: acc_d = rnd_res;
         default: acc_d = wr_src;
      endcase
   end

   // ----------------------------------------------------------------
   // Read paths
   // ----------------------------------------------------------------
   // A long read drives the first bus path from its own accumulator.
   wire logic first_acc = long_rd.valid ? long_rd.acc_sel
                                        : first_rd.acc_sel;
   // The second limiter serves single-word reads only; a long read takes
   // both halves from the first one so the pair saturates together.
   logic [23:0] lim1_upper, lim1_lower, lim2_upper;
   logic lim1_ovf, lim2_ovf;

   aslr_shift_limit u_first_lim (
      .acc(acc_q[first_acc]),
      .scale(scale),
      .upper(lim1_upper),
      .lower(lim1_lower),
      .ovf(lim1_ovf)
   );

   aslr_shift_limit u_second_lim (
      .acc(acc_q[second_rd.acc_sel]),
      .scale(scale),
      .upper(lim2_upper),
      .lower(),
      .ovf(lim2_ovf)
   );

   // Part reads bypass the shifter and the limiter altogether.
   wire logic first_full = first_rd.part == PART_FULL;
   wire logic second_full = second_rd.part == PART_FULL;

   always_comb begin
      first_d = '0;
      second_d = '0;
      if (long_rd.valid) begin
         first_d = '{valid: 1'b1, limited: lim1_ovf,
                     data: lim1_upper};
         second_d = '{valid: 1'b1, limited: lim1_ovf,
                      data: lim1_lower};
      end else begin
         if (first_rd.valid) begin
            first_d.valid = 1'b1;
            first_d.limited = first_full && lim1_ovf;
            first_d.data = first_full ? lim1_upper
                         : raw_part(acc_q[first_rd.acc_sel],
                                    first_rd.part);
         end
         if (second_rd.valid) begin
            second_d.valid = 1'b1;
            second_d.limited = second_full && lim2_ovf;
            second_d.data = second_full ? lim2_upper
                          : raw_part(acc_q[second_rd.acc_sel],
                                     second_rd.part);
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Reads take the accumulator value from before a same-cycle write;
   // the limiter never feeds back into storage.
   // Reset also clears the bus words, so no stale valid outlives it.
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         acc_q[0] <= '0;
         acc_q[1] <= '0;
         first_q <= '0;
         second_q <= '0;
      end else begin
         if (wr.valid) begin
            acc_q[wr.acc_sel] <= acc_d;
         end
         first_q <= first_d;
         second_q <= second_d;
      end
   end

   assign first_operand_bus = first_q;
   assign second_operand_bus = second_q;
   assign acc_a = acc_q[0];
   assign acc_b = acc_q[1];

endmodule

// >>> testbench/aslr_dp_properties.sv
`timescale 1ns/1ps
module aslr_dp_props (
   input wire logic mclk,
   input wire logic nrst,
   input wire aslr_pkg::aslr_scale_t scale,
   input wire aslr_pkg::aslr_wr_t wr,
   input wire aslr_pkg::aslr_rd_t first_rd,
   input wire aslr_pkg::aslr_rd_t second_rd,
   input wire aslr_pkg::aslr_long_rd_t long_rd,
   input wire aslr_pkg::aslr_bus_t first_operand_bus,
   input wire aslr_pkg::aslr_bus_t second_operand_bus,
   input wire logic [55:0] acc_a,
   input wire logic [55:0] acc_b
);
   import aslr_pkg::*;
   logic [55:0] pa_q;
   logic [47:0] wq;
   wire ovfa = acc_a[55:47] != 9'h000 && acc_a[55:47] != 9'h1ff;
   wire rd_fa = first_rd.valid && !long_rd.valid && !first_rd.acc_sel &&
      first_rd.part == PART_FULL;
   always_ff @(posedge mclk) begin
      pa_q <= acc_a;
      wq <= wr.data;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   chk_word_write: assert property (
      wr.valid && wr.op == OP_WORD && !wr.acc_sel |=>
      acc_a == {{8{wq[23]}}, wq[23:0], 24'h000000})
      else $error("word write image wrong");
   chk_long_write: assert property (
      wr.valid && wr.op == OP_LONG && wr.acc_sel |=>
      acc_b == {{8{wq[47]}}, wq}) else $error("long write image wrong");
   chk_part_raw: assert property (
      second_rd.valid && !long_rd.valid && !second_rd.acc_sel &&
      second_rd.part == PART_UPPER |=> !second_operand_bus.limited &&
      second_operand_bus.data == pa_q[47:24]) else $error("part read altered");
   chk_acc_kept: assert property (
      (long_rd.valid || rd_fa) && !wr.valid |=> $stable(acc_a))
      else $error("read changed accumulator");
   chk_sat_pos: assert property (
      rd_fa && scale == SCALE_NONE && ovfa && !acc_a[55] |=>
      first_operand_bus.limited && first_operand_bus.data == SAT_POS_WORD)
      else $error("positive saturation wrong");
   chk_sat_neg: assert property (
      rd_fa && scale == SCALE_NONE && ovfa && acc_a[55] |=>
      first_operand_bus.limited && first_operand_bus.data == SAT_NEG_WORD)
      else $error("negative saturation wrong");
   chk_scale_down: assert property (
      rd_fa && scale == SCALE_DOWN && acc_a[55:48] == 8'h00 |=>
      !first_operand_bus.limited && first_operand_bus.data == pa_q[48:25])
      else $error("scaled down read wrong");
   chk_round_low: assert property (
      wr.valid && wr.op == OP_RND && !wr.acc_sel |=> acc_a[23:0] == 24'h0)
      else $error("round left lower word set");
   cover property (rd_fa && ovfa);
   cover property (long_rd.valid);
   cover property (wr.valid && wr.op == OP_MPY);
endmodule

bind aslr_datapath aslr_dp_props u_props (.mclk(mclk), .nrst(nrst),
   .scale(scale), .wr(wr), .first_rd(first_rd), .second_rd(second_rd),
   .long_rd(long_rd), .first_operand_bus(first_operand_bus),
   .second_operand_bus(second_operand_bus), .acc_a(acc_a), .acc_b(acc_b));

// >>> testbench/aslr_bus_sink.sv
`timescale 1ns/1ps
// Memory side of both buses. A word is only offered for one cycle, so an
// idle cycle inverts the held copy to expose a missing valid pulse.
module aslr_bus_sink (
   input wire logic mclk,
   input wire aslr_pkg::aslr_bus_t first_operand_bus,
   input wire aslr_pkg::aslr_bus_t second_operand_bus,
   output logic [24:0] first_word,
   output logic [24:0] second_word
);
   import aslr_pkg::*;
   always @(posedge mclk) begin
      first_word <= first_operand_bus.valid ?
         {first_operand_bus.limited, first_operand_bus.data} : ~first_word;
      second_word <= second_operand_bus.valid ?
         {second_operand_bus.limited, second_operand_bus.data} : ~second_word;
   end
endmodule

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb;
   import aslr_pkg::*;
   logic mclk = 1'h0;
   logic nrst = 1'h0;
   aslr_scale_t scale = SCALE_NONE;
   aslr_wr_t wr = '0;
   aslr_rd_t first_rd = '0;
   aslr_rd_t second_rd = '0;
   aslr_long_rd_t long_rd = '0;
   aslr_bus_t first_operand_bus, second_operand_bus;
   logic [55:0] acc_a, acc_b;
   logic [24:0] first_word, second_word;
   int failures = 0;
   int n_compared = 0;
   always #5 mclk = ~mclk;
   aslr_datapath DUT (.mclk(mclk), .nrst(nrst), .scale(scale), .wr(wr),
      .first_rd(first_rd), .second_rd(second_rd), .long_rd(long_rd),
      .first_operand_bus(first_operand_bus),
      .second_operand_bus(second_operand_bus), .acc_a(acc_a), .acc_b(acc_b));
   aslr_bus_sink u_sink (.mclk(mclk), .first_operand_bus(first_operand_bus),
      .second_operand_bus(second_operand_bus), .first_word(first_word),
      .second_word(second_word));
   task automatic ck(input string n, input logic [55:0] e,
                     input logic [55:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Requests stay held until the next task replaces them, so no signal is
   // written twice in one time step when tasks run back to back.
   task automatic put(input logic s, input aslr_op_t op, input logic [47:0] d);
      wr = '{1'h1, s, op, d};
      @(posedge mclk);
      #1;
   endtask
   task automatic rd(input logic l, input logic s, input aslr_part_t fp,
                     input aslr_part_t sp);
      wr = '0;
      first_rd = '{1'h1, s, fp};
      second_rd = '{1'h1, s, sp};
      long_rd = '{l, s};
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic report_and_stop;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic t_write;
      put(0, OP_WORD, 48'h800001);
      ck("word", 56'hff_800001_000000, acc_a);
      put(1, OP_IMM, 48'h3f);
      ck("imm", 56'h00_3f0000_000000, acc_b);
      put(1, OP_LONG, 48'h123456_abcdef);
      ck("long", 56'h00_123456_abcdef, acc_b);
      put(0, OP_MPY, 48'hc00000_400000);
      ck("mpy", 56'hff_e00000_000000, acc_a);
   endtask
   task automatic t_sat(input logic neg);
      logic [55:0] a;
      logic [24:0] hi;
      logic [24:0] lo;
      a = {neg ? 8'hfe : 8'h01, 48'h400000_000000};
      hi = {1'h1, neg ? SAT_NEG_WORD : SAT_POS_WORD};
      lo = {1'h1, neg ? SAT_NEG_LOW : SAT_POS_LOW};
      put(0, OP_LONG, 48'h400000_000000);
      put(0, OP_EXT, {40'h0, a[55:48]});
      rd(0, 0, PART_FULL, PART_UPPER);
      ck("full", hi, first_word);
      ck("upper", 25'h0400000, second_word);
      ck("kept", a, acc_a);
      rd(1, 0, PART_UPPER, PART_UPPER);
      ck("long hi", hi, first_word);
      ck("long lo", lo, second_word);
   endtask
   task automatic t_scale;
      logic [24:0] e [3] = '{25'h0400000, 25'h0200000, 25'h17fffff};
      put(0, OP_WORD, 48'h400000);
      for (int i = 0; i < 3; i++) begin
         scale = aslr_scale_t'(i);
         rd(0, 0, PART_FULL, PART_FULL);
         ck("scaled", e[i], first_word);
      end
   endtask
   task automatic t_round;
      logic [47:0] d [4] = '{48'h000002_800000, 48'h000003_800000,
                              48'h000003_7fffff, 48'h000003_000000};
      logic [55:0] e [4] = '{56'h00_000002_000000, 56'h00_000004_000000,
                              56'h00_000003_000000, 56'h00_000004_000000};
      for (int i = 0; i < 4; i++) begin
         scale = i == 3 ? SCALE_DOWN : SCALE_NONE;
         put(0, OP_LONG, d[i]);
         put(0, OP_RND, 48'h0);
         ck("round", e[i], acc_a);
      end
   endtask
   // Part writes and reads on B, reserved scale, both buses saturating,
   // and a scale-down read that only fits after the shift.
   task automatic t_parts;
      put(1, OP_LONG, 48'h123456_abcdef);
      put(1, OP_EXT, 48'h80);
      put(1, OP_UPPER, 48'h654321);
      put(1, OP_LOWER, 48'h0f0f0f);
      ck("parts", 56'h80_654321_0f0f0f, acc_b);
      scale = SCALE_RSVD;
      rd(0, 1, PART_EXT, PART_LOWER);
      ck("ext", 25'h0ffff80, first_word);
      ck("lower", 25'h00f0f0f, second_word);
      rd(0, 1, PART_FULL, PART_FULL);
      ck("x sat", 25'h1800000, first_word);
      ck("y sat", 25'h1800000, second_word);
      rd(1, 1, PART_FULL, PART_FULL);
      ck("b long hi", 25'h1800000, first_word);
      ck("b long lo", 25'h1000000, second_word);
      ck("kept b", 56'h80_654321_0f0f0f, acc_b);
      put(0, OP_LONG, 48'hc00000_000000);
      put(0, OP_EXT, 48'h0);
      scale = SCALE_DOWN;
      rd(0, 0, PART_FULL, PART_UPPER);
      ck("down", 25'h0600000, first_word);
      ck("raw", 25'h0c00000, second_word);
   endtask
   // Mid-run reset with all requests idle.
   task automatic t_reset;
      wr = '0;
      first_rd = '0;
      second_rd = '0;
      long_rd = '0;
      nrst = 1'h0;
      @(posedge mclk);
      #1;
      nrst = 1'h1;
      ck("rst a", 56'h0, acc_a);
      ck("rst b", 56'h0, acc_b);
      ck("rst bus", 56'h0, first_operand_bus);
      @(posedge mclk);
      #1;
      ck("idle bus", 56'h0, second_operand_bus);
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      #1 nrst = 1'h1;
      @(posedge mclk);
      #1;
      t_write;
      t_sat(0);
      t_sat(1);
      t_scale;
      t_parts;
      t_reset;
      t_round;
      report_and_stop;
   end
   initial begin
      #20000;
      failures++;
      report_and_stop;
   end
endmodule
